// file: core/apc_defines.vh
// Overview of operation
// - registers sit at fixed byte offsets, reachable as words or single bytes.
// - buffer-load bit copies result registers into buffers at each end of conversion.
// - deglitch passes raw for 00, else two-of-two, two-of-three, three-of-five.
// - per-timer trigger enables; cleared bit blocks that timer's triggers.
// - timer, match and saturation stop conditions act only while enabled.
// - run bit shows running state; software forces it, hardware updates it.
// - slope bit selects counting up for 0 and down for 1.
// - output source picks mux or DAC; output enable gates the analog output.
// - swap bit inverts the comparator output used by the logic.
// - read-only status bit returns filtered comparator result.
// - channel three and two range fields: 250 mV, 1 V, 2 V, 11 reserved.
// - channel one and zero range bits: 250 mV for 0, 500 mV for 1.
// - trim has 4-bit temperature and 3-bit gain; load needs gain lsb written one.
// - without continuous mode: auto-zero per request, forced phase, or long-term compare.
// - continuous bit selects continuous time operation regardless of other bits.
// - successive-approximation enable replaces ramp generation.
// - prescaler divides by 1,2,4,8,16 for codes 000..100; feeds converter and filter.
// - resets: config 2000h, control f0f0h, fractional regs 8000h, rest zero.
`ifndef APC_DEFINES_VH
`define APC_DEFINES_VH
`define APC_OFS_CNF     5'h00
`define APC_OFS_CTL     5'h02
`define APC_OFS_OMR     5'h04
`define APC_OFS_VDIV    5'h06
`define APC_OFS_TRIM    5'h08
`define APC_OFS_INT     5'h10
`define APC_OFS_INTB    5'h12
`define APC_OFS_FRACT   5'h14
`define APC_OFS_FRACTB  5'h16
`define APC_OFS_IFG     5'h1a
`define APC_OFS_IE      5'h1c
`define APC_OFS_IV      5'h1e
`define APC_RST_CNF     16'h2000
`define APC_RST_CTL     16'hf0f0
`define APC_RST_FRACT   16'h8000
`define APC_MSK_CNF     16'h7fef
`define APC_MSK_OMR     16'h0f0f
`define APC_MSK_VDIV    16'h00ff
`define APC_MSK_INT     16'h00ff
`define APC_MSK_FRACT   16'hff00
`define APC_MSK_IRQ     16'h000f
`define APC_BIT_TIMER_ZERO_TRIGGER_EN   0
`define APC_BIT_TIMER_ONE_TRIGGER_EN   1
`define APC_BIT_COMPARATOR_POWER_EN   5
`define APC_BIT_DAC_BUFFER_POWER_EN    6
`define APC_BIT_LADDER_POWER_EN  7
`define APC_BIT_BUFFER_LOAD_ON_DONE   10
`define APC_BIT_TIMER_RESULT_RELOAD    11
`define APC_BIT_INTERNAL_REFERENCE_EN   13
`define APC_BIT_REFERENCE_PIN_EN  14
`define APC_BIT_OUTPUT_DRIVER_EN    0
`define APC_BIT_COMPARATOR_INVERT    1
`define APC_BIT_OUTPUT_SOURCE_SELECT    2
`define APC_BIT_SLOPE   3
`define APC_BIT_RUN     8
`define APC_BIT_SSTP    9
`define APC_BIT_CSTP    10
`define APC_BIT_TSTP    11
`define APC_BIT_SUCCESSIVE_APPROX_EN   3
`define APC_BIT_COMPARATOR_CONTINUOUS_MODE    8
`define APC_BIT_LONGTERM_ZEROED_COMPARE   9
`define APC_BIT_AZSW    10
`define APC_BIT_TSEL    0
`define APC_BIT_GLSB    9
`define APC_CLK_VLO     2'h0
`define APC_CLK_MCLK    2'h1
`define APC_CLK_SUBSYSTEM_CPU_CLOCK   2'h2
`define APC_DF_RAW      2'h0
`define APC_DF_2OF2     2'h1
`define APC_DF_2OF3     2'h2
`define APC_DF_3OF5     2'h3
`define APC_AZ_REQ      4'h1
`define APC_AZ_FORCE    4'h2
`define APC_AZ_LONG     4'h4
`define APC_AZ_CONT     4'h8
`endif

// file: core/apc_deglitch.v
`timescale 1ns/100ps
`include "apc_defines.vh"
module apc_deglitch (
   // clock and reset
   input  wire       clk_i,
   input  wire       rst_i,
   // control
   input  wire       sample_i,
   input  wire [1:0] setting_i,
   input  wire       raw_i,
   // result
   output reg        filt_o
);
   reg  [4:0] hist_reg;
   reg  [2:0] ones;
   reg  [2:0] need;
   reg  [2:0] span;
   reg        filt_next;
   integer    k;

   always @* begin
      ones = 3'h0;
      need = 3'h2;
      span = 3'h2;
      filt_next = filt_o;
      case (setting_i)
         `APC_DF_2OF2: begin
            need = 3'h2;
            span = 3'h2;
         end
         `APC_DF_2OF3: begin
            need = 3'h2;
            span = 3'h3;
         end
         `APC_DF_3OF5: begin
            need = 3'h3;
            span = 3'h5;
         end
         default: begin
            need = 3'h1;
            span = 3'h1;
         end
      endcase
      for (k = 0; k < 5; k = k + 1) begin
         if (k < span && hist_reg[k])
            ones = ones + 3'h1;
      end
      // majority in either direction before the output may change
      if (setting_i == `APC_DF_RAW)
         filt_next = raw_i;
      else if (ones >= need)
         filt_next = 1'b1;
      else if ((span - ones) >= need)
         filt_next = 1'b0;
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         hist_reg <= 5'h00;
         filt_o   <= 1'b0;
      end else begin
         if (sample_i)
            hist_reg <= {hist_reg[3:0], raw_i};
         filt_o <= filt_next;
      end
   end
endmodule

// file: core/apc_regs.v
// Design decision made here: the Wishbone slave port.
`timescale 1ns/100ps
`include "apc_defines.vh"
module apc_regs #(
   parameter [6:0] FUSE_TRIM = 7'h40
) (
   // clock and reset
   input  wire        clk_i,
   input  wire        rst_i,
   // wishbone slave
   input  wire        cyc_i,
   input  wire        stb_i,
   input  wire        we_i,
   input  wire [4:0]  adr_i,
   input  wire [1:0]  sel_i,
   input  wire [15:0] dat_i,
   output reg  [15:0] dat_o,
   output reg         ack_o,
   // clock sources
   input  wire        very_low_power_osc_clock_i,
   input  wire        master_clock_i,
   input  wire        subsystem_cpu_clock_i,
   // converter events
   input  wire        timer_zero_event_i,
   input  wire        timer_one_event_i,
   input  wire        conv_done_i,
   input  wire        saturation_i,
   input  wire        comparator_raw_i,
   input  wire        hw_start_i,
   input  wire [7:0]  conv_int_i,
   input  wire [7:0]  conv_fract_i,
   // analog controls
   output wire        conv_clock_o,
   output reg         conv_tick_o,
   output wire        trigger_o,
   output wire        converter_running_o,
   output wire        count_down_o,
   output wire        successive_approx_en_o,
   output wire        ladder_power_en_o,
   output wire        dac_buffer_power_en_o,
   output wire        comparator_power_en_o,
   output wire        internal_reference_en_o,
   output wire        reference_pin_en_o,
   output wire        output_source_select_o,
   output wire        output_driver_en_o,
   output wire        comparator_used_o,
   output wire [3:0]  zeroing_mode_o,
   output wire [1:0]  ch3_range_select_o,
   output wire [1:0]  ch2_range_select_o,
   output wire        ch1_range_select_o,
   output wire        ch0_range_select_o,
   output wire [3:0]  trim_temperature_part_o,
   output wire [2:0]  trim_gain_part_o
);
   reg  [15:0] cnf_reg;
   reg  [15:0] ctl_reg;
   reg  [15:0] omr_reg;
   reg  [15:0] vdiv_reg;
   reg  [6:0]  trim_reg;
   reg         tsel_reg;
   reg  [15:0] int_reg;
   reg  [15:0] intb_reg;
   reg  [15:0] fract_reg;
   reg  [15:0] fractb_reg;
   reg  [15:0] ifg_reg;
   reg  [15:0] ie_reg;
   reg  [15:0] iv_reg;
   reg  [3:0]  pre_reg;
   reg  [15:0] rd;
   reg  [15:0] wmask;
   reg  [1:0]  vlo_sync_reg;
   reg  [1:0]  mclk_sync_reg;
   reg  [1:0]  subsystem_cpu_clock_sync_reg;
   reg         src_prev_reg;
   reg  [3:0]  pre_lim;
   wire        filtered_comparator_state;
   wire        src;
   wire        src_rise;
   wire        wr;
   wire [1:0]  conv_clock_select;
   wire [6:0]  trim_view;
   wire        stop_hit;

   // register bus: ack the cycle after the strobe; a write lands at the ack edge
   assign wr = cyc_i & stb_i & we_i & ack_o;
   always @* begin
      wmask = {{8{sel_i[1]}}, {8{sel_i[0]}}};
   end

   // clock sources are sampled; switching between them can produce a false rising edge and tick
   assign conv_clock_select = cnf_reg[9:8];
   assign src = (conv_clock_select == `APC_CLK_MCLK)  ? mclk_sync_reg[1]  :
                (conv_clock_select == `APC_CLK_SUBSYSTEM_CPU_CLOCK) ? subsystem_cpu_clock_sync_reg[1] :
                vlo_sync_reg[1];
   assign conv_clock_o = src;
   assign src_rise = src & ~src_prev_reg;

   always @* begin
      case (omr_reg[2:0])
         3'h0:    pre_lim = 4'h0;
         3'h1:    pre_lim = 4'h1;
         3'h2:    pre_lim = 4'h3;
         3'h3:    pre_lim = 4'h7;
         default: pre_lim = 4'hf;
      endcase
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         vlo_sync_reg   <= 2'h0;
         mclk_sync_reg  <= 2'h0;
         subsystem_cpu_clock_sync_reg <= 2'h0;
         src_prev_reg   <= 1'b0;
         pre_reg        <= 4'h0;
         conv_tick_o    <= 1'b0;
      end else begin
         vlo_sync_reg   <= {vlo_sync_reg[0], very_low_power_osc_clock_i};
         mclk_sync_reg  <= {mclk_sync_reg[0], master_clock_i};
         subsystem_cpu_clock_sync_reg <= {subsystem_cpu_clock_sync_reg[0], subsystem_cpu_clock_i};
         src_prev_reg   <= src;
         conv_tick_o    <= 1'b0;
         if (src_rise) begin
            if (pre_reg >= pre_lim) begin
               pre_reg     <= 4'h0;
               conv_tick_o <= 1'b1;
            end else
               pre_reg <= pre_reg + 4'h1;
         end
      end
   end

   apc_deglitch u_filt (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .sample_i  (conv_tick_o),
      .setting_i (cnf_reg[3:2]),
      .raw_i     (comparator_raw_i),
      .filt_o    (filtered_comparator_state)
   );

   assign comparator_used_o = filtered_comparator_state ^ ctl_reg[`APC_BIT_COMPARATOR_INVERT];
   assign trigger_o = (timer_zero_event_i & cnf_reg[`APC_BIT_TIMER_ZERO_TRIGGER_EN]) |
                      (timer_one_event_i & cnf_reg[`APC_BIT_TIMER_ONE_TRIGGER_EN]);
   assign stop_hit = (ctl_reg[`APC_BIT_TSTP] & trigger_o) |
                     (ctl_reg[`APC_BIT_CSTP] & comparator_used_o) |
                     (ctl_reg[`APC_BIT_SSTP] & saturation_i);
   assign converter_running_o     = ctl_reg[`APC_BIT_RUN];
   assign count_down_o            = ctl_reg[`APC_BIT_SLOPE];
   assign successive_approx_en_o  = omr_reg[`APC_BIT_SUCCESSIVE_APPROX_EN];
   assign ladder_power_en_o       = cnf_reg[`APC_BIT_LADDER_POWER_EN];
   assign dac_buffer_power_en_o   = cnf_reg[`APC_BIT_DAC_BUFFER_POWER_EN];
   assign comparator_power_en_o   = cnf_reg[`APC_BIT_COMPARATOR_POWER_EN];
   assign internal_reference_en_o = cnf_reg[`APC_BIT_INTERNAL_REFERENCE_EN];
   assign reference_pin_en_o      = cnf_reg[`APC_BIT_REFERENCE_PIN_EN];
   assign output_source_select_o  = ctl_reg[`APC_BIT_OUTPUT_SOURCE_SELECT];
   assign output_driver_en_o      = ctl_reg[`APC_BIT_OUTPUT_DRIVER_EN];
   assign zeroing_mode_o = omr_reg[`APC_BIT_COMPARATOR_CONTINUOUS_MODE]  ? `APC_AZ_CONT :
                           omr_reg[`APC_BIT_AZSW]  ? `APC_AZ_FORCE :
                           omr_reg[`APC_BIT_LONGTERM_ZEROED_COMPARE] ? `APC_AZ_LONG : `APC_AZ_REQ;
   assign ch3_range_select_o = vdiv_reg[5:4];
   assign ch2_range_select_o = vdiv_reg[3:2];
   assign ch1_range_select_o = vdiv_reg[1];
   assign ch0_range_select_o = vdiv_reg[0];
   assign trim_view = tsel_reg ? trim_reg : FUSE_TRIM;
   assign trim_temperature_part_o = trim_view[6:3];
   assign trim_gain_part_o        = trim_view[2:0];

   always @* begin
      case (adr_i)
         `APC_OFS_CNF:    rd = cnf_reg;
         `APC_OFS_CTL:    rd = ctl_reg;
         `APC_OFS_OMR:    rd = omr_reg;
         `APC_OFS_VDIV:   rd = {7'h00, filtered_comparator_state, vdiv_reg[7:0]};
         `APC_OFS_TRIM:   rd = {trim_view, 8'h00, tsel_reg};
         `APC_OFS_INT:    rd = int_reg;
         `APC_OFS_INTB:   rd = intb_reg;
         `APC_OFS_FRACT:  rd = fract_reg;
         `APC_OFS_FRACTB: rd = fractb_reg;
         `APC_OFS_IFG:    rd = ifg_reg;
         `APC_OFS_IE:     rd = ie_reg;
         `APC_OFS_IV:     rd = iv_reg;
         default:         rd = 16'h0000;
      endcase
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_o      <= 1'b0;
         dat_o      <= 16'h0000;
         cnf_reg    <= `APC_RST_CNF;
         ctl_reg    <= `APC_RST_CTL;
         omr_reg    <= 16'h0000;
         vdiv_reg   <= 16'h0000;
         trim_reg   <= 7'h00;
         tsel_reg   <= 1'b0;
         int_reg    <= 16'h0000;
         intb_reg   <= 16'h0000;
         fract_reg  <= `APC_RST_FRACT;
         fractb_reg <= `APC_RST_FRACT;
         ifg_reg    <= 16'h0000;
         ie_reg     <= 16'h0000;
         iv_reg     <= 16'h0000;
      end else begin
         ack_o <= cyc_i & stb_i & ~ack_o;
         if (cyc_i & stb_i & ~ack_o)
            dat_o <= rd;
         // hardware updates first, so a same-cycle software write wins for data
         if (conv_done_i) begin
            int_reg   <= {8'h00, conv_int_i};
            fract_reg <= {conv_fract_i, 8'h00};
            if (cnf_reg[`APC_BIT_BUFFER_LOAD_ON_DONE]) begin
               intb_reg   <= {8'h00, conv_int_i};
               fractb_reg <= {conv_fract_i, 8'h00};
            end
         end
         if (timer_one_event_i & cnf_reg[`APC_BIT_TIMER_RESULT_RELOAD]) begin
            int_reg   <= intb_reg;
            fract_reg <= fractb_reg;
         end
         if (wr) begin
            case (adr_i)
               `APC_OFS_CNF:
                  cnf_reg <= (cnf_reg & ~(wmask & `APC_MSK_CNF)) |
                             (dat_i & wmask & `APC_MSK_CNF);
               `APC_OFS_CTL: ctl_reg <= (ctl_reg & ~wmask) | (dat_i & wmask);
               `APC_OFS_OMR:
                  omr_reg <= (omr_reg & ~(wmask & `APC_MSK_OMR)) |
                             (dat_i & wmask & `APC_MSK_OMR);
               `APC_OFS_VDIV:
                  vdiv_reg <= (vdiv_reg & ~(wmask & `APC_MSK_VDIV)) |
                              (dat_i & wmask & `APC_MSK_VDIV);
               `APC_OFS_TRIM: begin
                  if (sel_i[0])
                     tsel_reg <= dat_i[`APC_BIT_TSEL];
                  if (sel_i[1] && tsel_reg && dat_i[`APC_BIT_GLSB])
                     trim_reg <= dat_i[15:9];
               end
               `APC_OFS_INT:
                  int_reg <= (int_reg & ~(wmask & `APC_MSK_INT)) |
                             (dat_i & wmask & `APC_MSK_INT);
               `APC_OFS_INTB:
                  intb_reg <= (intb_reg & ~(wmask & `APC_MSK_INT)) |
                              (dat_i & wmask & `APC_MSK_INT);
               `APC_OFS_FRACT:
                  fract_reg <= (fract_reg & ~(wmask & `APC_MSK_FRACT)) |
                               (dat_i & wmask & `APC_MSK_FRACT);
               `APC_OFS_FRACTB:
                  fractb_reg <= (fractb_reg & ~(wmask & `APC_MSK_FRACT)) |
                                (dat_i & wmask & `APC_MSK_FRACT);
               `APC_OFS_IFG:
                  ifg_reg <= (ifg_reg & ~(wmask & `APC_MSK_IRQ)) |
                             (dat_i & wmask & `APC_MSK_IRQ);
               `APC_OFS_IE:
                  ie_reg <= (ie_reg & ~(wmask & `APC_MSK_IRQ)) |
                            (dat_i & wmask & `APC_MSK_IRQ);
               default: iv_reg <= iv_reg;
            endcase
         end
         // run state: hardware start/stop acts unless software writes the byte
         if (!(wr && adr_i == `APC_OFS_CTL && sel_i[1])) begin
            if (stop_hit && ctl_reg[`APC_BIT_RUN])
               ctl_reg[`APC_BIT_RUN] <= 1'b0;
            else if (hw_start_i || (trigger_o && !ctl_reg[`APC_BIT_RUN]))
               ctl_reg[`APC_BIT_RUN] <= 1'b1;
         end
      end
   end
endmodule

// file: verification/apc_regs_properties.sv
`timescale 1ns/100ps
module apc_regs_properties (
   // clock, reset, bus
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic        ack_o,
   input wire logic [15:0] dat_o,
   // events and views
   input wire logic        timer_zero_event_i,
   input wire logic        timer_one_event_i,
   input wire logic        hw_start_i,
   input wire logic        trigger_o,
   input wire logic        conv_tick_o,
   input wire logic        converter_running_o,
   input wire logic        ladder_power_en_o,
   input wire logic [3:0]  zeroing_mode_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("request not answered");
   a_ack_single: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
      else $error("ack without request");
   a_reset_quiet: assert property ($past(rst_i) |-> !ack_o && dat_o == 16'h0)
      else $error("bus not idle after reset");
   a_trigger_cause: assert property (trigger_o |-> timer_zero_event_i || timer_one_event_i)
      else $error("trigger without timer event");
   a_stopped_stays: assert property (!converter_running_o && !hw_start_i && !trigger_o
      && !(cyc_i && stb_i && we_i) |=> !converter_running_o)
      else $error("converter started by itself");
   a_tick_single: assert property (conv_tick_o |=> !conv_tick_o)
      else $error("tick longer than one cycle");
   a_zero_onehot: assert property ($onehot(zeroing_mode_o))
      else $error("zeroing mode not one-hot");
   a_power_hold: assert property (!$stable(ladder_power_en_o) |-> $past(cyc_i && stb_i && we_i))
      else $error("ladder enable changed without a write");
endmodule

bind apc_regs apc_regs_properties u_apc_regs_properties (.*);

// file: verification/apc_regs_tb_top.sv
`timescale 1ns/100ps
`include "apc_defines.vh"
module apc_regs_tb_top;
   localparam logic [6:0] FUSE = 7'h40;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o;
   logic [4:0] adr_i = 5'h0;
   logic [1:0] sel_i = 2'h0;
   logic [15:0] dat_i = 16'h0, dat_o;
   logic [3:0] ck = 4'h0;
   logic timer_zero_event_i = 1'b0, timer_one_event_i = 1'b0, conv_done_i = 1'b0;
   logic saturation_i = 1'b0, comparator_raw_i = 1'b0, hw_start_i = 1'b0;
   logic [7:0] conv_int_i = 8'h0, conv_fract_i = 8'h0;
   // counter-derived slow clocks: 1/16, 1/4 and 1/8 of the bus clock
   wire very_low_power_osc_clock_i = ck[3];
   wire master_clock_i = ck[1];
   wire subsystem_cpu_clock_i = ck[2];
   logic conv_clock_o, conv_tick_o, trigger_o, converter_running_o, count_down_o;
   logic successive_approx_en_o, ladder_power_en_o, dac_buffer_power_en_o;
   logic comparator_power_en_o, internal_reference_en_o, reference_pin_en_o;
   logic output_source_select_o, output_driver_en_o, comparator_used_o;
   logic ch1_range_select_o, ch0_range_select_o;
   logic [1:0] ch3_range_select_o, ch2_range_select_o;
   logic [3:0] zeroing_mode_o, trim_temperature_part_o;
   logic [2:0] trim_gain_part_o;
   int failures = 0, check_count = 0, ticks = 0;
   logic [4:0] ofs [7] = '{`APC_OFS_INT, `APC_OFS_INTB, `APC_OFS_FRACT, `APC_OFS_FRACTB,
                           `APC_OFS_IFG, `APC_OFS_IE, 5'h0c};
   logic [15:0] msk [7] = '{`APC_MSK_INT, `APC_MSK_INT, `APC_MSK_FRACT, `APC_MSK_FRACT,
                            `APC_MSK_IRQ, `APC_MSK_IRQ, 16'h0};

   apc_regs #(.FUSE_TRIM(FUSE)) u_apc_regs (.*);

   always #20 clk_i = ~clk_i;
   always @(posedge clk_i) ck <= ck + 4'h1;
   always @(posedge clk_i) if (conv_tick_o === 1'b1) ticks <= ticks + 1;

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // classic single cycle, held until ack is sampled high
   task automatic wb(input logic w, input logic [4:0] a, input logic [1:0] s,
                     input logic [15:0] d, output logic [15:0] q);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      sel_i <= s;
      dat_i <= d;
      // only the watchdog ends a wait that never sees ack
      do
         @(posedge clk_i);
      while (ack_o !== 1'b1);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      logic [15:0] q;
      wb(1'b1, a, 2'h3, d, q);
   endtask

   task automatic rd(input logic [4:0] a, input logic [15:0] e);
      logic [15:0] q;
      wb(1'b0, a, 2'h3, 16'h0, q);
      chk(q, e);
   endtask

   // {saturation, done, timer one, timer zero}, one cycle
   task automatic ev(input logic [3:0] e);
      {saturation_i, conv_done_i, timer_one_event_i, timer_zero_event_i} <= e;
      @(posedge clk_i);
      {saturation_i, conv_done_i, timer_one_event_i, timer_zero_event_i} <= 4'h0;
      @(posedge clk_i);
   endtask

   task automatic measure(input logic [15:0] c, input logic [2:0] dv, input int n);
      int t;
      wr(`APC_OFS_CNF, c);
      wr(`APC_OFS_OMR, {13'h0, dv});
      repeat (16) @(posedge clk_i);
      t = ticks;
      repeat (512) @(posedge clk_i);
      t = ticks - t - n;
      chk({15'h0, t * t <= 1}, 16'h1);
   endtask

   function automatic logic [3:0] zexp(input logic [2:0] m);
      if (m[0]) return `APC_AZ_CONT;
      if (m[2]) return `APC_AZ_FORCE;
      if (m[1]) return `APC_AZ_LONG;
      return `APC_AZ_REQ;
   endfunction

   initial begin
      logic [15:0] c, t, o, d, q;
      int i, k;
      void'($urandom(32'h1c73e15f));
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(`APC_OFS_CNF, `APC_RST_CNF);
      rd(`APC_OFS_CTL, `APC_RST_CTL);
      rd(`APC_OFS_FRACTB, `APC_RST_FRACT);
      rd(`APC_OFS_TRIM, {FUSE, 9'h0});
      chk({15'h0, internal_reference_en_o}, 16'h1);
      $display("test reset done");
      for (i = 0; i < 8; i++) begin
         c = $urandom;
         t = $urandom & 16'hfeff;
         o = $urandom;
         d = $urandom;
         o[10:8] = i[2:0];
         wr(`APC_OFS_CNF, c);
         wr(`APC_OFS_CTL, t);
         wr(`APC_OFS_OMR, o);
         wr(`APC_OFS_VDIV, d);
         rd(`APC_OFS_CNF, c & `APC_MSK_CNF);
         rd(`APC_OFS_OMR, o & `APC_MSK_OMR);
         rd(`APC_OFS_VDIV, d & `APC_MSK_VDIV);
         chk({ladder_power_en_o, dac_buffer_power_en_o, comparator_power_en_o,
              internal_reference_en_o, reference_pin_en_o, output_source_select_o,
              output_driver_en_o, count_down_o, successive_approx_en_o, ch3_range_select_o,
              ch2_range_select_o, ch1_range_select_o, ch0_range_select_o, 1'b0},
             {c[7:5], c[13], c[14], t[2], t[0], t[3], o[3], d[5:0], 1'b0});
         chk({12'h0, zeroing_mode_o}, {12'h0, zexp(o[10:8])});
      end
      for (k = 0; k < 7; k++) begin
         c = $urandom;
         wr(ofs[k], c);
         rd(ofs[k], c & msk[k]);
      end
      wr(`APC_OFS_CTL, 16'h5a00);
      wb(1'b1, `APC_OFS_CTL, 2'h1, 16'hfff3, q);
      rd(`APC_OFS_CTL, 16'h5af3);
      wb(1'b1, `APC_OFS_CTL, 2'h2, 16'h20ff, q);
      rd(`APC_OFS_CTL, 16'h20f3);
      $display("test registers done");
      wr(`APC_OFS_TRIM, 16'hffff);
      rd(`APC_OFS_TRIM, 16'h0001);
      wr(`APC_OFS_TRIM, 16'ha201);
      wr(`APC_OFS_TRIM, 16'h5c01);
      rd(`APC_OFS_TRIM, 16'ha201);
      chk({9'h0, trim_temperature_part_o, trim_gain_part_o}, 16'h0051);
      wr(`APC_OFS_TRIM, 16'h0000);
      rd(`APC_OFS_TRIM, {FUSE, 9'h0});
      $display("test trim done");
      wr(`APC_OFS_CNF, 16'h2000);
      wr(`APC_OFS_INTB, 16'h00a5);
      wr(`APC_OFS_FRACTB, 16'h5a00);
      o = 16'h5a00;
      for (i = 0; i < 2; i++) begin
         c = $urandom;
         {conv_fract_i, conv_int_i} <= c;
         ev(4'h4);
         rd(`APC_OFS_INT, {8'h0, c[7:0]});
         rd(`APC_OFS_INTB, i ? {8'h0, c[7:0]} : 16'h00a5);
         rd(`APC_OFS_FRACTB, i ? {c[15:8], 8'h0} : o & `APC_MSK_FRACT);
         o = c;
         wr(`APC_OFS_CNF, 16'h2400);
      end
      wr(`APC_OFS_CNF, 16'h2800);
      wr(`APC_OFS_INTB, 16'h003c);
      ev(4'h2);
      rd(`APC_OFS_INT, 16'h003c);
      wr(`APC_OFS_CNF, 16'h2000);
      wr(`APC_OFS_INTB, 16'h0077);
      ev(4'h2);
      rd(`APC_OFS_INT, 16'h003c);
      $display("test results done");
      wr(`APC_OFS_CTL, 16'h0100);
      ev(4'h8);
      rd(`APC_OFS_CTL, 16'h0100);
      wr(`APC_OFS_CTL, 16'h0300);
      ev(4'h8);
      rd(`APC_OFS_CTL, 16'h0200);
      hw_start_i <= 1'b1;
      @(posedge clk_i);
      hw_start_i <= 1'b0;
      @(posedge clk_i);
      rd(`APC_OFS_CTL, 16'h0300);
      wr(`APC_OFS_CNF, 16'h2001);
      wr(`APC_OFS_CTL, 16'h0900);
      ev(4'h1);
      rd(`APC_OFS_CTL, 16'h0800);
      ev(4'h1);
      rd(`APC_OFS_CTL, 16'h0900);
      for (i = 0; i < 16; i++) begin
         wr(`APC_OFS_CNF, {14'h0800, i[3:2]});
         {timer_one_event_i, timer_zero_event_i} <= i[1:0];
         @(negedge clk_i);
         chk({15'h0, trigger_o}, {15'h0, |(i[3:2] & i[1:0])});
         @(posedge clk_i);
         {timer_one_event_i, timer_zero_event_i} <= 2'h0;
         @(posedge clk_i);
      end
      wr(`APC_OFS_CTL, 16'h0000);
      $display("test run and trigger done");
      for (i = 0; i < 4; i++)
         measure({6'h08, i[1:0], 8'h0}, 3'h0, i == 1 ? 128 : i == 2 ? 64 : 32);
      for (i = 0; i < 5; i++)
         measure(16'h2100, i[2:0], 128 >> i);
      $display("test clocks done");
      wr(`APC_OFS_OMR, 16'h0000);
      wr(`APC_OFS_VDIV, 16'h0000);
      wr(`APC_OFS_CTL, 16'h0002);
      for (i = 0; i < 4; i++) begin
         wr(`APC_OFS_CNF, {12'h210, i[1:0], 2'h0});
         comparator_raw_i <= i[0];
         repeat (40) @(posedge clk_i);
         rd(`APC_OFS_VDIV, {7'h0, i[0], 8'h0});
         chk({15'h0, comparator_used_o}, {15'h0, ~i[0]});
         // a glitch of one tick period reaches exactly one filter sample
         comparator_raw_i <= ~i[0];
         repeat (3) @(posedge clk_i);
         @(negedge clk_i);
         chk({15'h0, comparator_used_o}, {15'h0, i[0] ^ (i != 0)});
         @(posedge clk_i);
         comparator_raw_i <= i[0];
         repeat (40) @(posedge clk_i);
         if (i > 0) rd(`APC_OFS_VDIV, {7'h0, i[0], 8'h0});
      end
      $display("test deglitch done");
      report_and_stop;
   end

   initial begin
      repeat (30000) @(posedge clk_i);
      failures++;
      report_and_stop;
   end
endmodule
